// ---- hw/lfm_fault_mgr.sv ----
// led driver fault bookkeeping, masking and error reporting
//
// Notes on behaviour
// - qualified open/short over width+deglitch flags, pulses
// - off-state test pulse sets done, result, pulse
// - checksum mismatch sets flag, maskable global, pulse
// - diagnostic flags hold until clear bit written
// - fail-safe keeps detecting and reporting all faults
// - policy bit one selects all-off, else others-on
// - fail-safe all-off policy: any led fault kills all
// - fail-safe others-on policy: only faulty channel switched off
// - flags stay readable in fail-safe
// - masks stop reporting, never detection
// - diag enable zero hides channel faults completely
// - ref, temp, checksum masks block global and pin
// - open, short masks block summary, global, pin
// - rail undervoltage to por, then init, flags
// - supply under threshold sets low-supply and global
// - clear-fault write resets flags, bit self-clears
// - newest 8-bit supply code overwrites result
// - reference fault holds pin low, sets flags
// - fail-safe reference fault: all off, auto recover
// - watchdog overflow enters fail-safe; exit bit returns
`timescale 1ns/100ps
module lfm_fault_mgr (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write channels
   input wire logic [lfm_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read channels
   input wire logic [lfm_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // analog detector levels
   input wire logic [lfm_pkg::NCH-1:0] chan_pwm_on,
   input wire logic [lfm_pkg::NCH-1:0] chan_open_det,
   input wire logic [lfm_pkg::NCH-1:0] chan_short_det,
   input wire logic ref_fault_det,
   input wire logic overtemp_det,
   input wire logic rail_uvlo_det,
   input wire logic wd_overflow,
   // converter and nonvolatile memory
   input wire logic adc_supply_valid,
   input wire logic [7:0] adc_supply_code,
   input wire logic nvm_check_valid,
   input wire logic [7:0] computed_nvm_checksum,
   input wire logic [7:0] stored_nvm_checksum,
   input wire logic all_off_policy_bit,
   // channel drive
   output logic [lfm_pkg::NCH-1:0] chan_drive,
   output logic [lfm_pkg::NCH-1:0] diag_test_drive,
   output logic [lfm_pkg::CUR_W-1:0] diag_test_current,
   // open-drain error pin
   input wire logic err_pin_i,
   output logic err_pin_o,
   output logic err_pin_oe
);
   localparam int N = lfm_pkg::NCH;
   typedef enum {ST_POR, ST_INIT, ST_NORMAL, ST_FAILSAFE} lfm_state_type;
   typedef enum {OD_IDLE, OD_RUN} lfm_od_type;

   lfm_state_type state_reg;
   lfm_od_type od_state_reg;
   lfm_pkg::lfm_mask_type mask_reg;
   lfm_pkg::lfm_gflag_type gflag_reg, gflag_set;
   logic [N-1:0] chan_output_enable, chan_diag_enable;
   logic [7:0] low_supply_threshold, diag_pulse_width, supply_reg;
   logic [N-1:0] chan_open_flag, chan_short_flag;
   logic [N-1:0] ondemand_chan_result_flag, od_target_reg;
   logic [N-1:0] open_hit, short_hit, led_fault;
   logic [7:0] od_cnt_reg;
   logic [11:0] pulse_cnt_reg, pulse_cnt_next;
   logic [lfm_pkg::ADDR_W-1:0] awaddr_reg;
   logic [31:0] wdata_reg, rd_data;
   logic [3:0] wstrb_reg;
   logic wr_fire, rd_hit, wr_hit, fault_flag_clear, failsafe_exit_clear;
   logic offstate_diag_trigger, od_finish, crc_bad, low_sup_evt;
   logic pulse_evt, hold_low, supply_ok, failsafe, all_off;
   logic [9:0] diag_limit;

   function automatic logic [31:0] merge(input logic [31:0] old_w,
      input logic [31:0] new_w, input logic [3:0] strb);
      logic [31:0] res;
      res = old_w;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
            res[8*b +: 8] = new_w[8*b +: 8];
      end
      return res;
   endfunction

   // ---------------------------------------------------------
   // bus write path
   // ---------------------------------------------------------
   assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wr_hit = awaddr_reg == lfm_pkg::OFS_CTRL
      || awaddr_reg == lfm_pkg::OFS_CHEN
      || awaddr_reg == lfm_pkg::OFS_CONF;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= lfm_pkg::RESP_OKAY;
         awaddr_reg <= '0;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awaddr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? lfm_pkg::RESP_OKAY
               : lfm_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // configuration and one-cycle command bits
   always_ff @(posedge aclk)
   begin
      logic [31:0] w;
      w = 32'h0000_0000;
      if (!aresetn)
      begin
         mask_reg <= lfm_pkg::MASK_RST;
         chan_output_enable <= lfm_pkg::CHEN_RST;
         chan_diag_enable <= lfm_pkg::CHEN_RST;
         low_supply_threshold <= lfm_pkg::LOWSUP_RST;
         diag_pulse_width <= lfm_pkg::PW_RST;
         diag_test_current <= lfm_pkg::CUR_RST;
         fault_flag_clear <= 1'b0;
         failsafe_exit_clear <= 1'b0;
         offstate_diag_trigger <= 1'b0;
      end
      else
      begin
         fault_flag_clear <= 1'b0;
         failsafe_exit_clear <= 1'b0;
         offstate_diag_trigger <= 1'b0;
         if (wr_fire && awaddr_reg == lfm_pkg::OFS_CTRL)
         begin
            w = merge({19'h0_0000, mask_reg, 8'h00}, wdata_reg, wstrb_reg);
            mask_reg <= w[lfm_pkg::CTRL_MASK_LSB +: 5];
            fault_flag_clear <= w[lfm_pkg::CTRL_FAULT_FLAG_CLEAR_BIT];
            failsafe_exit_clear <= w[lfm_pkg::CTRL_FAILSAFE_EXIT_CLEAR_BIT];
            offstate_diag_trigger <= w[lfm_pkg::CTRL_OD_TRIG_BIT];
         end
         if (wr_fire && awaddr_reg == lfm_pkg::OFS_CHEN)
         begin
            w = merge({4'h0, chan_diag_enable, 4'h0, chan_output_enable},
               wdata_reg, wstrb_reg);
            chan_output_enable <= w[lfm_pkg::CHEN_OUT_LSB +: N];
            chan_diag_enable <= w[lfm_pkg::CHEN_DIAG_LSB +: N];
         end
         if (wr_fire && awaddr_reg == lfm_pkg::OFS_CONF)
         begin
            w = merge({10'h000, diag_test_current, diag_pulse_width,
               low_supply_threshold}, wdata_reg, wstrb_reg);
            low_supply_threshold <= w[lfm_pkg::CONF_LOWSUP_LSB +: 8];
            diag_pulse_width <= w[lfm_pkg::CONF_PW_LSB +: 8];
            diag_test_current <= w[lfm_pkg::CONF_CUR_LSB +: lfm_pkg::CUR_W];
         end
      end
   end

   // ---------------------------------------------------------
   // bus read path
   // ---------------------------------------------------------
   always_comb
   begin
      rd_hit = 1'b1;
      case (s_axi_araddr)
         lfm_pkg::OFS_CTRL: rd_data = {19'h0_0000, mask_reg, 8'h00};
         lfm_pkg::OFS_CHEN:
            rd_data = {4'h0, chan_diag_enable, 4'h0, chan_output_enable};
         lfm_pkg::OFS_CONF: rd_data = {10'h000, diag_test_current,
            diag_pulse_width, low_supply_threshold};
         lfm_pkg::OFS_LEDFLAG:
            rd_data = {4'h0, chan_short_flag, 4'h0, chan_open_flag};
         lfm_pkg::OFS_STAT:
            rd_data = {4'h0, ondemand_chan_result_flag, 7'h00, gflag_reg};
         lfm_pkg::OFS_SUPPLY: rd_data = {24'h00_0000, supply_reg};
         default:
         begin
            rd_data = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   // flags stay readable in every state
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= lfm_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_data;
         s_axi_rresp <= rd_hit ? lfm_pkg::RESP_OKAY : lfm_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ---------------------------------------------------------
   // device state
   // ---------------------------------------------------------
   assign failsafe = state_reg == ST_FAILSAFE;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         state_reg <= ST_POR;
      else if (rail_uvlo_det)
         state_reg <= ST_POR;
      else
         case (state_reg)
            ST_POR: state_reg <= ST_INIT;
            ST_INIT: state_reg <= ST_NORMAL;
            ST_NORMAL:
               if (wd_overflow)
                  state_reg <= ST_FAILSAFE;
            ST_FAILSAFE:
               if (failsafe_exit_clear)
                  state_reg <= ST_NORMAL;
            default: state_reg <= ST_POR;
         endcase
   end

   // ---------------------------------------------------------
   // per-channel on-time detection
   // ---------------------------------------------------------
   assign supply_ok = supply_reg > low_supply_threshold;
   assign diag_limit = {2'b00, diag_pulse_width} + lfm_pkg::DEGLITCH_CYC;

   for (genvar g = 0; g < N; g++)
   begin : g_chan
      logic [9:0] open_cnt_reg, short_cnt_reg;
      logic qual, open_cond, short_cond;
      assign qual = chan_pwm_on[g] && chan_output_enable[g]
         && chan_diag_enable[g];
      assign open_cond = qual && chan_open_det[g] && supply_ok;
      assign short_cond = qual && chan_short_det[g];
      assign open_hit[g] = open_cond && open_cnt_reg == diag_limit - 10'h001;
      assign short_hit[g] = short_cond
         && short_cnt_reg == diag_limit - 10'h001;
      always_ff @(posedge aclk)
      begin
         if (!aresetn || !open_cond)
            open_cnt_reg <= 10'h000;
         else if (open_cnt_reg != diag_limit)
            open_cnt_reg <= open_cnt_reg + 10'h001;
      end
      always_ff @(posedge aclk)
      begin
         if (!aresetn || !short_cond)
            short_cnt_reg <= 10'h000;
         else if (short_cnt_reg != diag_limit)
            short_cnt_reg <= short_cnt_reg + 10'h001;
      end
   end

   // sticky channel flags, set wins over clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         chan_open_flag <= '0;
         chan_short_flag <= '0;
      end
      else
      begin
         chan_open_flag <= (chan_open_flag & ~{N{fault_flag_clear}})
            | open_hit;
         chan_short_flag <= (chan_short_flag & ~{N{fault_flag_clear}})
            | short_hit;
      end
   end

   // ---------------------------------------------------------
   // off-state test pulse
   // ---------------------------------------------------------
   assign od_finish = od_state_reg == OD_RUN && od_cnt_reg == 8'h00;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         od_state_reg <= OD_IDLE;
         od_cnt_reg <= 8'h00;
         od_target_reg <= '0;
         diag_test_drive <= '0;
         ondemand_chan_result_flag <= '0;
      end
      else
      begin
         ondemand_chan_result_flag <= ondemand_chan_result_flag
            & ~{N{fault_flag_clear}};
         case (od_state_reg)
            OD_IDLE:
               if (offstate_diag_trigger)
               begin
                  od_state_reg <= OD_RUN;
                  od_cnt_reg <= diag_pulse_width;
                  od_target_reg <= ~chan_output_enable & chan_diag_enable;
                  diag_test_drive <= ~chan_output_enable & chan_diag_enable;
               end
            OD_RUN:
               if (od_finish)
               begin
                  od_state_reg <= OD_IDLE;
                  diag_test_drive <= '0;
                  ondemand_chan_result_flag <= (ondemand_chan_result_flag
                     & ~{N{fault_flag_clear}})
                     | (od_target_reg & (chan_open_det | chan_short_det));
               end
               else
                  od_cnt_reg <= od_cnt_reg - 8'h01;
            default: od_state_reg <= OD_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------
   // global flags and supply result
   // ---------------------------------------------------------
   assign crc_bad = nvm_check_valid
      && computed_nvm_checksum != stored_nvm_checksum;
   assign low_sup_evt = adc_supply_valid
      && adc_supply_code < low_supply_threshold;

   always_comb
   begin
      gflag_set = '0;
      gflag_set.summary = |(open_hit & ~{N{mask_reg.open}})
         || |(short_hit & ~{N{mask_reg.shrt}}) || od_finish;
      gflag_set.por = state_reg == ST_INIT;
      gflag_set.low_sup = low_sup_evt;
      gflag_set.refr = ref_fault_det;
      gflag_set.temp = overtemp_det;
      gflag_set.crc = crc_bad;
      gflag_set.failsafe = state_reg == ST_NORMAL && wd_overflow;
      gflag_set.od_done = od_finish;
      gflag_set.global = gflag_set.summary || gflag_set.por || low_sup_evt
         || (ref_fault_det && !mask_reg.refr)
         || (overtemp_det && !mask_reg.temp)
         || (crc_bad && !mask_reg.crc);
   end

   // reference flag stays until cleared after removal
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         gflag_reg <= '0;
      else
         gflag_reg <= (gflag_reg
            & ~(fault_flag_clear ? 9'h17F : 9'h000)
            & ~(failsafe_exit_clear ? 9'h080 : 9'h000))
            | gflag_set;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         supply_reg <= 8'h00;
      else if (adc_supply_valid)
         supply_reg <= adc_supply_code;
   end

   // ---------------------------------------------------------
   // error pin and channel drive
   // ---------------------------------------------------------
   assign led_fault = (chan_open_flag | chan_short_flag) & chan_diag_enable;
   assign pulse_evt = gflag_set.summary || low_sup_evt
      || (crc_bad && !mask_reg.crc);
   assign hold_low = state_reg == ST_POR
      || (ref_fault_det && !mask_reg.refr)
      || (overtemp_det && !mask_reg.temp);
   assign pulse_cnt_next = pulse_evt ? lfm_pkg::ERR_PULSE_LOAD
      : (pulse_cnt_reg != 12'h000 ? pulse_cnt_reg - 12'h001
      : 12'h000);
   assign all_off = (all_off_policy_bit && |led_fault)
      || ref_fault_det || overtemp_det;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pulse_cnt_reg <= 12'h000;
         err_pin_oe <= 1'b0;
         err_pin_o <= 1'b0;
         chan_drive <= '0;
      end
      else
      begin
         pulse_cnt_reg <= pulse_cnt_next;
         err_pin_oe <= hold_low || pulse_cnt_next != 12'h000;
         err_pin_o <= 1'b0;
         if (state_reg == ST_POR)
            chan_drive <= '0;
         else if (failsafe && all_off)
            chan_drive <= '0;
         else if (failsafe)
            chan_drive <= chan_output_enable & ~led_fault;
         else
            chan_drive <= chan_output_enable;
      end
   end

   // ---------------------------------------------------------
   // checks
   // ---------------------------------------------------------
   a_pulse_load: assert property (@(posedge aclk) disable iff (!aresetn)
      pulse_evt |=> pulse_cnt_reg == lfm_pkg::ERR_PULSE_LOAD && err_pin_oe)
      else $error("error pulse not started");
   a_pulse_end: assert property (@(posedge aclk) disable iff (!aresetn)
      pulse_cnt_reg == 12'h001 && !pulse_evt && !hold_low |=> !err_pin_oe)
      else $error("error pulse overran");
   a_clear_self: assert property (@(posedge aclk) disable iff (!aresetn)
      fault_flag_clear |=> !fault_flag_clear)
      else $error("clear bit did not return");
   a_flag_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
      open_hit != '0 |=> (chan_open_flag & $past(open_hit)) == $past(open_hit))
      else $error("open flag lost");
   a_mask_summary: assert property (@(posedge aclk) disable iff (!aresetn)
      !gflag_reg.summary && mask_reg.open && mask_reg.shrt && !od_finish
      |=> !gflag_reg.summary)
      else $error("masked fault reached summary");
   a_all_off_policy: assert property (@(posedge aclk) disable iff (!aresetn)
      failsafe && all_off_policy_bit && led_fault != '0 |=> chan_drive == '0)
      else $error("channels left on");
   a_ref_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      ref_fault_det && !mask_reg.refr |=> err_pin_oe && gflag_reg.refr)
      else $error("reference fault not held");
   a_fs_entry: assert property (@(posedge aclk) disable iff (!aresetn)
      state_reg == ST_NORMAL && wd_overflow && !rail_uvlo_det
      |=> failsafe && gflag_reg.failsafe)
      else $error("fail-safe not entered");
   a_por_recover: assert property (@(posedge aclk) disable iff (!aresetn)
      state_reg == ST_POR && !rail_uvlo_det
      |=> state_reg == ST_INIT ##1 gflag_reg.por && gflag_reg.global)
      else $error("por recovery wrong");
   a_crc_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      crc_bad |=> gflag_reg.crc)
      else $error("checksum flag missing");
   a_supply_upd: assert property (@(posedge aclk) disable iff (!aresetn)
      adc_supply_valid |=> supply_reg == $past(adc_supply_code))
      else $error("supply result stale");
endmodule

// ---- hw/lfm_pkg.sv ----
// constants and types for the led fault manager
package lfm_pkg;
   // channels and bus
   localparam int NCH = 12;
   localparam int ADDR_W = 8;
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CHEN = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_CONF = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_LEDFLAG = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_STAT = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_SUPPLY = 8'h14;
   // control register fields
   localparam int CTRL_FAULT_FLAG_CLEAR_BIT = 0;
   localparam int CTRL_FAILSAFE_EXIT_CLEAR_BIT = 1;
   localparam int CTRL_OD_TRIG_BIT = 2;
   localparam int CTRL_MASK_LSB = 8;
   // channel enable register fields
   localparam int CHEN_OUT_LSB = 0;
   localparam int CHEN_DIAG_LSB = 16;
   // configuration register fields
   localparam int CONF_LOWSUP_LSB = 0;
   localparam int CONF_PW_LSB = 8;
   localparam int CONF_CUR_LSB = 16;
   localparam int CUR_W = 6;
   // flag register fields
   localparam int LED_OPEN_LSB = 0;
   localparam int LED_SHORT_LSB = 16;
   localparam int STAT_OD_LSB = 16;
   // reset values
   localparam logic [4:0] MASK_RST = 5'h00;
   localparam logic [NCH-1:0] CHEN_RST = 12'h000;
   localparam logic [7:0] LOWSUP_RST = 8'h00;
   localparam logic [7:0] PW_RST = 8'h10;
   localparam logic [CUR_W-1:0] CUR_RST = 6'h00;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // timing
   localparam int CLK_MHZ = 40;
   localparam int ERR_PULSE_NS = 50000;
   localparam int ERR_PULSE_CYC = ERR_PULSE_NS * CLK_MHZ / 1000;
   localparam logic [11:0] ERR_PULSE_LOAD = 12'(ERR_PULSE_CYC);
   localparam logic [9:0] DEGLITCH_CYC = 10'h010;
   // maskable fault types
   typedef struct packed {
      logic crc;
      logic temp;
      logic shrt;
      logic open;
      logic refr;
   } lfm_mask_type;
   // sticky global flags
   typedef struct packed {
      logic od_done;
      logic failsafe;
      logic crc;
      logic temp;
      logic refr;
      logic low_sup;
      logic por;
      logic summary;
      logic global;
   } lfm_gflag_type;
endpackage

// ---- sim/lfm_master_model.sv ----
// axi4-lite master standing in for the controller
`timescale 1ns/100ps
module lfm_master_model (
   // clock
   input wire logic aclk,
   // bus master side
   output logic [7:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   output logic bready,
   output logic [7:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   initial {awaddr, araddr, wdata, awvalid, wvalid, arvalid} = '0;
   assign {wstrb, bready, rready} = 6'h3F;
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic ta, tw, b;
      @(posedge aclk);
      {awaddr, wdata, awvalid, wvalid} <= {a, v, 2'h3};
      {ta, tw, b} = 3'h0;
      while (!b)
      begin
         @(negedge aclk);
         {ta, tw, b} = {ta | awready, tw | wready, bvalid};
         @(posedge aclk);
         {awvalid, wvalid} <= {awvalid & ~ta, wvalid & ~tw};
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v,
      output logic [1:0] r);
      logic ta, t;
      @(posedge aclk);
      {araddr, arvalid} <= {a, 1'b1};
      {ta, t} = 2'h0;
      while (!t)
      begin
         @(negedge aclk);
         {ta, t, v, r} = {ta | arready, rvalid, rdata, rresp};
         @(posedge aclk);
         arvalid <= arvalid & ~ta;
      end
   endtask
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench for the led fault manager
`timescale 1ns/100ps
module tb_top;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] pwm = '0, opn = '0, sht = '0, drive, tdrv;
   logic wd = 1'b0, adc_v = 1'b0, nvm_v = 1'b0, pol = 1'b0;
   logic rf = 1'b0, uv = 1'b0, oe;
   logic [7:0] adc_c = '0, crc_c = '0, awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] rresp, r, bresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   int fails = 0, samples_checked = 0;
   always #12.5 aclk = ~aclk;
   lfm_master_model lfm_master_model_inst (.aclk(aclk), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   lfm_fault_mgr lfm_fault_mgr_inst (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .chan_pwm_on(pwm),
      .chan_open_det(opn), .chan_short_det(sht), .ref_fault_det(rf),
      .overtemp_det(1'b0), .rail_uvlo_det(uv), .wd_overflow(wd),
      .adc_supply_valid(adc_v), .adc_supply_code(adc_c),
      .nvm_check_valid(nvm_v), .computed_nvm_checksum(adc_c),
      .stored_nvm_checksum(crc_c), .all_off_policy_bit(pol),
      .chan_drive(drive), .diag_test_drive(tdrv), .diag_test_current(),
      .err_pin_i(1'b1), .err_pin_o(), .err_pin_oe(oe));
   task automatic chk(input string n, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e)
      begin
         fails++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      lfm_master_model_inst.rd(a, d, r);
      chk("rdata", e, d);
   endtask
   task automatic dchk(input logic [11:0] e, input logic eo);
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk("drive", 32'(e), 32'(drive));
      chk("err_pin_oe", 32'(eo), 32'(oe));
      @(posedge aclk);
   endtask
   task automatic final_report;
      if (fails == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      repeat (5000) @(posedge aclk);
      fails++;
      final_report();
   end
   initial
   begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      rchk(8'h10, 32'h0000_0005);
      lfm_master_model_inst.wr(8'h00, 32'h0000_0401);
      rchk(8'h00, 32'h0000_0400);
      rchk(8'h10, 32'h0000_0000);
      lfm_master_model_inst.rd(8'h18, d, r);
      chk("rresp", 32'(lfm_pkg::RESP_SLVERR), 32'(r));
      lfm_master_model_inst.wr(8'h0C, 32'h0000_0000);
      chk("bresp", 32'(lfm_pkg::RESP_SLVERR), 32'(bresp));
      {adc_c, adc_v, nvm_v} <= {8'h80, 2'h3};
      @(posedge aclk);
      {adc_v, nvm_v} <= 2'h0;
      rchk(8'h14, 32'h0000_0080);
      rchk(8'h10, 32'h0000_0041);
      lfm_master_model_inst.wr(8'h00, 32'h0000_0401);
      lfm_master_model_inst.wr(8'h04, 32'h0007_0003);
      {pwm, sht} <= {12'h003, 12'h001};
      repeat (40) @(posedge aclk);
      rchk(8'h0C, 32'h0001_0000);
      rchk(8'h10, 32'h0000_0000);
      {sht, opn} <= {12'h000, 12'h001};
      repeat (40) @(posedge aclk);
      {sht, opn} <= {12'h004, 12'h000};
      dchk(12'h003, 1'b1);
      rchk(8'h0C, 32'h0001_0001);
      rchk(8'h10, 32'h0000_0003);
      lfm_master_model_inst.wr(8'h00, 32'h0000_0404);
      @(negedge aclk);
      chk("test_drive", 32'h0000_0004, 32'(tdrv));
      repeat (20) @(posedge aclk);
      rchk(8'h10, 32'h0004_0103);
      {pol, wd} <= 2'h3;
      @(posedge aclk);
      wd <= 1'b0;
      dchk(12'h000, 1'b1);
      rchk(8'h10, 32'h0004_0183);
      pol <= 1'b0;
      dchk(12'h002, 1'b1);
      rf <= 1'b1;
      dchk(12'h000, 1'b1);
      rchk(8'h10, 32'h0004_0193);
      rf <= 1'b0;
      dchk(12'h002, 1'b1);
      lfm_master_model_inst.wr(8'h00, 32'h0000_0402);
      lfm_master_model_inst.wr(8'h00, 32'h0000_0401);
      dchk(12'h003, 1'b1);
      rchk(8'h10, 32'h0000_0000);
      lfm_master_model_inst.wr(8'h08, 32'h0000_1090);
      adc_v <= 1'b1;
      @(posedge aclk);
      adc_v <= 1'b0;
      rchk(8'h10, 32'h0000_0009);
      uv <= 1'b1;
      @(posedge aclk);
      uv <= 1'b0;
      repeat (2) @(posedge aclk);
      rchk(8'h10, 32'h0000_000D);
      repeat (2000) @(posedge aclk);
      dchk(12'h003, 1'b0);
      final_report();
   end
endmodule
